// file: logic/uhcmi_top.sv
`timescale 1ns/1ns
`include "uhcmi_cfg.svh"
// Contract
// - chip select high ignores strobes, floats bus
// - port select high command, low data
// - command read returns token, bit7 interrupt level
// - write loads command or data by port
// - data port read drives next input byte
// - interrupt request output is active low
// - serial frame: start, nine data, stop
// - ninth bit one command, zero data
// - serial rate 9600 after reset, changeable
// - serial interface allows host mode only
// - activity output low once device attached
// - external reset high, extended about 20 ms
// - reset status outputs during any reset
// - 12 MHz clock, 48 MHz engine reference; core clock here is 20 MHz
// - engine handles USB line-level protocol work
// - endpoint 0 and port 1 eight-byte buffers
// - port 2 has 64-byte buffers
// - host buffers reuse port 2 storage
// - endpoints 0 to 15, lengths 0 to 64
// - interrupt on bus change or command done
// - serial output pin strapped during reset

module uhcmi_top
  import uhcmi_pkg::*;
#(
  parameter int unsigned RESET_EXT_CYCLES = `UHCMI_RESET_EXT_CYC,
  parameter int unsigned BUF_BYTES        = `UHCMI_BUF_BYTES
) (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ext_reset_in_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        port_select_i,
  input  wire logic [7:0]  host_data_bus_i,
  output logic [7:0]       host_data_bus_o,
  output logic             host_data_bus_oe_n_o,
  output logic             int_n_o,
  input  wire logic        rxd_i,
  input  wire logic        txd_i,
  output logic             txd_o,
  output logic             txd_oe_n_o,
  output logic             act_n_o,
  output logic             rst_o,
  output logic             rst_n_o,
  output logic             serial_mode_o,
  output logic             device_mode_en_o,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_code_o,
  output logic             data_valid_o,
  output logic [7:0]       data_o,
  output logic             data_rd_ack_o,
  input  wire logic [6:0]  token_status_i,
  input  wire logic        bus_change_i,
  input  wire logic        cmd_done_i,
  input  wire logic        dev_attached_i,
  input  wire logic        link_div_load_i,
  input  wire logic [15:0] link_div_i,
  input  wire logic        ser_tx_valid_i,
  input  wire logic [7:0]  ser_tx_data_i,
  output logic             ser_tx_ready_o,
  input  wire logic [5:0]  sie_out_addr_i,
  output logic [7:0]       sie_out_data_o,
  input  wire logic        sie_in_wr_i,
  input  wire logic [5:0]  sie_in_addr_i,
  input  wire logic [7:0]  sie_in_data_i,
  output logic [6:0]       out_len_o
);

  localparam int unsigned CW = $clog2(RESET_EXT_CYCLES + 1);
  localparam int unsigned PW = 7;
  localparam logic [PW-1:0] BUF_END = PW'(BUF_BYTES);

  if (RESET_EXT_CYCLES < 1 || BUF_BYTES < 1 || BUF_BYTES > 64) begin : g_chk
    $error("uhcmi_top: unsupported reset length or buffer size");
  end

  // reset extension and strap
  logic [1:0]    ext_sync;
  logic [CW-1:0] ext_cnt;
  logic [1:0]    strap_sync;
  logic          serial_mode;

  wire logic core_rst = ext_sync[1] | (ext_cnt != '0);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_sync   <= 2'b11;
      strap_sync <= 2'b00;
    end else begin
      ext_sync   <= {ext_sync[0], ext_reset_in_i};
      strap_sync <= {strap_sync[0], txd_i};
    end
  end

  // power-up also runs the full extension
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_cnt <= CW'(RESET_EXT_CYCLES);
    end else if (ext_sync[1]) begin
      ext_cnt <= CW'(RESET_EXT_CYCLES);
    end else if (ext_cnt != '0) begin
      ext_cnt <= ext_cnt - CW'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_o            <= 1'b1;
      rst_n_o          <= 1'b0;
      serial_mode      <= 1'b0;
      serial_mode_o    <= 1'b0;
      device_mode_en_o <= 1'b0;
      act_n_o          <= 1'b1;
      txd_oe_n_o       <= 1'b1;
    end else begin
      rst_o   <= core_rst;
      rst_n_o <= ~core_rst;
      // last level seen before release wins
      if (core_rst) begin
        serial_mode <= strap_sync[1];
      end
      serial_mode_o    <= serial_mode;
      device_mode_en_o <= ~serial_mode & ~core_rst;
      act_n_o          <= core_rst | ~dev_attached_i;
      // pin is released while strapping
      txd_oe_n_o       <= core_rst | ~serial_mode;
    end
  end

  // parallel pin synchronisers
  logic [11:0] pin_s1;
  logic [11:0] pin_s2;
  logic        rd_act_q;
  logic        wr_act_q;
  logic        rd_ps_q;
  logic        wr_ps_q;
  logic [7:0]  wr_byte_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1 <= `UHCMI_PIN_RST;
      pin_s2 <= `UHCMI_PIN_RST;
    end else begin
      pin_s1 <= {cs_n_i, rd_n_i, wr_n_i, port_select_i, host_data_bus_i};
      pin_s2 <= pin_s1;
    end
  end

  wire logic       cs_n_s = pin_s2[11];
  wire logic       rd_n_s = pin_s2[10];
  wire logic       wr_n_s = pin_s2[9];
  wire logic       ps_s   = pin_s2[8];
  wire logic [7:0] bus_s  = pin_s2[7:0];

  wire logic sel    = ~cs_n_s & ~serial_mode & ~core_rst;
  // write wins when both strobes are low, as with a tied read
  wire logic wr_act = sel & ~wr_n_s;
  wire logic rd_act = sel & ~rd_n_s & wr_n_s;
  // an access ends on the strobe or chip select rising
  wire logic wr_end = wr_act_q & ~wr_act;
  wire logic rd_end = rd_act_q & ~rd_act;

  wire logic par_cmd  = wr_end & wr_ps_q;
  wire logic par_data = wr_end & ~wr_ps_q;
  wire logic tok_rd   = rd_end & rd_ps_q;
  wire logic data_rd  = rd_end & ~rd_ps_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_act_q  <= 1'b0;
      wr_act_q  <= 1'b0;
      rd_ps_q   <= 1'b0;
      wr_ps_q   <= 1'b0;
      wr_byte_q <= 8'h00;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (rd_act) begin
        rd_ps_q <= ps_s;
      end
      // keep the last byte seen while the strobe is low
      if (wr_act) begin
        wr_ps_q   <= ps_s;
        wr_byte_q <= bus_s;
      end
    end
  end

  // serial link
  logic [1:0]  rxd_sync;
  logic [15:0] link_div;
  logic        rx_valid;
  logic [8:0]  rx_word;
  logic        link_txd;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxd_sync <= 2'b11;
      link_div <= `UHCMI_LINK_DIV_DEF;
      txd_o    <= 1'b1;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd_i};
      txd_o    <= link_txd;
      if (core_rst) begin
        link_div <= `UHCMI_LINK_DIV_DEF;
      end else if (link_div_load_i && link_div_i > 16'h0001) begin
        link_div <= link_div_i;
      end
    end
  end

  wire logic ser_on  = serial_mode & ~core_rst;
  wire logic ser_cmd = ser_on & rx_valid & rx_word[`UHCMI_LINK_CMD_BIT];
  wire logic ser_dat = ser_on & rx_valid & ~rx_word[`UHCMI_LINK_CMD_BIT];

  uhcmi_link #(
    .DIV_W (16)
  ) u_link (
    .mclk_i     (mclk_i),
    .arst_n_i   (arst_n_i),
    .clr_i      (~ser_on),
    .div_i      (link_div),
    .rxd_i      (rxd_sync[1]),
    .rx_valid_o (rx_valid),
    .rx_word_o  (rx_word),
    .tx_valid_i (ser_tx_valid_i),
    .tx_word_i  ({1'b0, ser_tx_data_i}),
    .tx_ready_o (ser_tx_ready_o),
    .txd_o      (link_txd)
  );

  // command and data strobes towards the interpreter
  wire logic       cmd_stb  = par_cmd | ser_cmd;
  wire logic       dat_stb  = par_data | ser_dat;
  wire logic [7:0] in_byte  = ser_on ? rx_word[7:0] : wr_byte_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_valid_o  <= 1'b0;
      cmd_code_o   <= 8'h00;
      data_valid_o <= 1'b0;
      data_o       <= 8'h00;
    end else begin
      cmd_valid_o  <= cmd_stb;
      data_valid_o <= dat_stb;
      if (cmd_stb) begin
        cmd_code_o <= in_byte;
      end
      if (dat_stb) begin
        data_o <= in_byte;
      end
    end
  end

  // host buffers share the port 2 storage: out is downstream, in upstream
  uhcmi_byte_type out_buf [BUF_BYTES];
  uhcmi_byte_type in_buf  [BUF_BYTES];
  logic [PW-1:0]  wr_ptr;
  logic [PW-1:0]  rd_ptr;

  wire logic       wr_room  = (wr_ptr < BUF_END);
  wire logic       rd_room  = (rd_ptr < BUF_END);
  wire logic [5:0] wr_addr  = wr_ptr[5:0];
  wire logic [5:0] rd_addr  = rd_ptr[5:0];
  // reading past the buffer end returns zero rather than stale bytes
  wire logic [7:0] rd_byte  = rd_room ? in_buf[rd_addr] : 8'h00;
  wire logic [7:0] token    = {int_n_o, token_status_i};
  wire logic [7:0] bus_next = ps_s ? token : rd_byte;

  always_ff @(posedge mclk_i) begin
    if (dat_stb && wr_room) begin
      out_buf[wr_addr] <= in_byte;
    end
    if (sie_in_wr_i && ({1'b0, sie_in_addr_i} < BUF_END)) begin
      in_buf[sie_in_addr_i] <= sie_in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    sie_out_data_o <= out_buf[sie_out_addr_i];
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      out_len_o     <= 7'h00;
      data_rd_ack_o <= 1'b0;
    end else begin
      data_rd_ack_o <= data_rd;
      out_len_o     <= wr_ptr;
      if (core_rst || cmd_stb) begin
        // each command starts its own data phase
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (dat_stb && wr_room) begin
          wr_ptr <= wr_ptr + PW'(1);
        end
        if (data_rd && rd_room) begin
          rd_ptr <= rd_ptr + PW'(1);
        end
      end
    end
  end

  // bus drive: enable low only while a read is under way
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_data_bus_o      <= 8'h00;
      host_data_bus_oe_n_o <= 1'b1;
    end else begin
      host_data_bus_oe_n_o <= ~rd_act;
      if (rd_act) begin
        host_data_bus_o <= bus_next;
      end
    end
  end

  // interrupt: the event wins over a token read in the same cycle
  wire logic irq_set = ~core_rst & (bus_change_i | cmd_done_i);
  wire logic irq_hold = ~int_n_o & ~tok_rd & ~core_rst;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= ~(irq_set | irq_hold);
    end
  end

endmodule : uhcmi_top

// file: logic/uhcmi_cfg.svh
`ifndef UHCMI_CFG_SVH
`define UHCMI_CFG_SVH

// core clock
`define UHCMI_CLK_HZ          20000000
// documented crystal and engine reference rates
`define UHCMI_OSC_HZ          12000000
`define UHCMI_SIE_REF_HZ      48000000

// reset extension after the external reset falls
`define UHCMI_RESET_EXT_MS    20
`define UHCMI_RESET_EXT_CYC   (`UHCMI_RESET_EXT_MS * (`UHCMI_CLK_HZ / 1000))

// serial link
`define UHCMI_LINK_BAUD_DEF   9600
`define UHCMI_LINK_DIV_W      16
`define UHCMI_LINK_DIV_DEF    16'(`UHCMI_CLK_HZ / `UHCMI_LINK_BAUD_DEF)
`define UHCMI_LINK_DATA_BITS  9
`define UHCMI_LINK_CMD_BIT    8

// interrupt token
`define UHCMI_TOKEN_IRQ_BIT   7

// endpoint layout
`define UHCMI_EP0_BYTES       8
`define UHCMI_EP1_BYTES       8
`define UHCMI_EP1_IN_NUM      8'h81
`define UHCMI_EP1_OUT_NUM     8'h01
`define UHCMI_EP2_BYTES       64
`define UHCMI_EP2_IN_NUM      8'h82
`define UHCMI_EP2_OUT_NUM     8'h02
`define UHCMI_BUF_BYTES       64
`define UHCMI_EP_NUM_MAX      15

// pin synchroniser reset image: cs_n, rd_n, wr_n, port_select, data
`define UHCMI_PIN_RST         12'he00

`endif

// file: logic/uhcmi_pkg.sv
package uhcmi_pkg;

  typedef enum logic [1:0] {
    UHCMI_LK_IDLE,
    UHCMI_LK_START,
    UHCMI_LK_BITS,
    UHCMI_LK_STOP
  } uhcmi_link_state_type;

  typedef logic [7:0] uhcmi_byte_type;

endpackage : uhcmi_pkg

// file: logic/uhcmi_link.sv
`timescale 1ns/1ns
`include "uhcmi_cfg.svh"

module uhcmi_link
  import uhcmi_pkg::*;
#(
  parameter int unsigned DIV_W = `UHCMI_LINK_DIV_W
) (
  input  wire logic             mclk_i,
  input  wire logic             arst_n_i,
  input  wire logic             clr_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             rxd_i,
  output logic                  rx_valid_o,
  output logic [8:0]            rx_word_o,
  input  wire logic             tx_valid_i,
  input  wire logic [8:0]       tx_word_i,
  output logic                  tx_ready_o,
  output logic                  txd_o
);

  if (DIV_W < 2) begin : g_chk
    $error("uhcmi_link: DIV_W too small");
  end

  uhcmi_link_state_type rx_state;
  logic [DIV_W-1:0]     rx_cnt;
  logic [3:0]           rx_idx;
  logic [8:0]           rx_sh;
  logic [DIV_W-1:0]     tx_cnt;
  logic [3:0]           tx_left;
  logic [10:0]          tx_sh;

  wire logic             rx_tick = (rx_cnt == '0);
  wire logic [DIV_W-1:0] bit_rld = div_i - DIV_W'(1);
  wire logic             tx_tick = (tx_cnt == '0);
  wire logic             tx_take = tx_ready_o & tx_valid_i;

  // receiver samples each bit at its middle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_state   <= UHCMI_LK_IDLE;
      rx_cnt     <= '0;
      rx_idx     <= 4'h0;
      rx_sh      <= 9'h000;
      rx_valid_o <= 1'b0;
      rx_word_o  <= 9'h000;
    end else begin
      rx_valid_o <= 1'b0;
      if (clr_i) begin
        rx_state <= UHCMI_LK_IDLE;
      end else begin
        if (!rx_tick) begin
          rx_cnt <= rx_cnt - DIV_W'(1);
        end
        case (rx_state)
          UHCMI_LK_IDLE: begin
            if (!rxd_i) begin
              rx_state <= UHCMI_LK_START;
              rx_cnt   <= div_i >> 1;
            end
          end
          UHCMI_LK_START: begin
            if (rx_tick) begin
              // a glitch shorter than half a bit is not a start
              rx_state <= rxd_i ? UHCMI_LK_IDLE : UHCMI_LK_BITS;
              rx_cnt   <= bit_rld;
              rx_idx   <= 4'h0;
            end
          end
          UHCMI_LK_BITS: begin
            if (rx_tick) begin
              rx_sh  <= {rxd_i, rx_sh[8:1]};
              rx_cnt <= bit_rld;
              rx_idx <= rx_idx + 4'h1;
              if (rx_idx == 4'(`UHCMI_LINK_DATA_BITS - 1)) begin
                rx_state <= UHCMI_LK_STOP;
              end
            end
          end
          UHCMI_LK_STOP: begin
            if (rx_tick) begin
              // framing errors are dropped silently
              rx_valid_o <= rxd_i;
              rx_word_o  <= rx_sh;
              rx_state   <= UHCMI_LK_IDLE;
            end
          end
          default: rx_state <= UHCMI_LK_IDLE;
        endcase
      end
    end
  end

  // transmitter: start, nine data bits lsb first, stop
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_cnt     <= '0;
      tx_left    <= 4'h0;
      tx_sh      <= 11'h7ff;
      tx_ready_o <= 1'b1;
      txd_o      <= 1'b1;
    end else if (clr_i) begin
      tx_left    <= 4'h0;
      tx_ready_o <= 1'b1;
      txd_o      <= 1'b1;
    end else if (tx_take) begin
      tx_sh      <= {1'b1, tx_word_i, 1'b0};
      tx_left    <= 4'd11;
      tx_cnt     <= '0;
      tx_ready_o <= 1'b0;
    end else if (tx_left != 4'h0) begin
      if (tx_tick) begin
        txd_o   <= tx_sh[0];
        tx_sh   <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
        tx_cnt  <= bit_rld;
      end else begin
        tx_cnt <= tx_cnt - DIV_W'(1);
      end
    end else if (tx_tick) begin
      tx_ready_o <= 1'b1;
    end else begin
      tx_cnt <= tx_cnt - DIV_W'(1);
    end
  end

endmodule : uhcmi_link

// file: bench/uhcmi_top_properties.sv
`timescale 1ns/1ns
module uhcmi_top_properties #(
  parameter int unsigned RESET_EXT_CYCLES = 400000
) (
  input wire logic       mclk_i,
  input wire logic       arst_n_i,
  input wire logic       ext_reset_in_i,
  input wire logic       cs_n_i,
  input wire logic       port_select_i,
  input wire logic [7:0] host_data_bus_o,
  input wire logic       host_data_bus_oe_n_o,
  input wire logic       int_n_o,
  input wire logic       txd_oe_n_o,
  input wire logic       act_n_o,
  input wire logic       rst_o,
  input wire logic       rst_n_o,
  input wire logic       serial_mode_o,
  input wire logic       device_mode_en_o,
  input wire logic       cmd_valid_o,
  input wire logic       data_rd_ack_o,
  input wire logic       bus_change_i,
  input wire logic       cmd_done_i,
  input wire logic       dev_attached_i
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  int unsigned quiet;

  // saturates so a long quiet spell cannot wrap
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      quiet <= 0;
    else if (ext_reset_in_i)
      quiet <= 0;
    else if (quiet < RESET_EXT_CYCLES + 8)
      quiet <= quiet + 1;
  end

  cs_idle_a: assert property (cs_n_i [*6] |-> host_data_bus_oe_n_o)
    else $error("data bus driven while deselected");
  bus_refused_a: assert property (!host_data_bus_oe_n_o |->
    !rst_o && !serial_mode_o)
    else $error("data bus driven in reset or serial mode");
  token_bit_a: assert property (port_select_i [*5] ##0
    (!host_data_bus_oe_n_o && $stable(int_n_o)) |->
    host_data_bus_o[7] == int_n_o)
    else $error("token bit 7 differs from interrupt level");
  irq_set_a: assert property (!rst_o && (bus_change_i || cmd_done_i)
    |=> !int_n_o)
    else $error("event did not raise interrupt");
  rst_pair_a: assert property (rst_n_o == !rst_o)
    else $error("reset status outputs not complementary");
  rst_min_a: assert property ($fell(rst_o) |->
    quiet >= RESET_EXT_CYCLES)
    else $error("reset extension too short");
  rst_max_a: assert property (rst_o |-> quiet <= RESET_EXT_CYCLES + 5)
    else $error("reset extension too long");
  act_level_a: assert property ((!rst_o && $stable(dev_attached_i)) [*4]
    |-> act_n_o == !dev_attached_i)
    else $error("activity output wrong");
  serial_host_a: assert property (serial_mode_o |-> !device_mode_en_o)
    else $error("device mode allowed on serial link");
  txd_float_a: assert property (!serial_mode_o |-> txd_oe_n_o)
    else $error("serial output driven in parallel mode");
  read_ack_a: assert property (data_rd_ack_o |->
    host_data_bus_oe_n_o && !$past(host_data_bus_oe_n_o))
    else $error("read done without a driven read");

  cmd_seen_c: cover property (cmd_valid_o);
  irq_seen_c: cover property ($fell(int_n_o));
  read_seen_c: cover property (data_rd_ack_o);
endmodule : uhcmi_top_properties

bind uhcmi_top uhcmi_top_properties #(
  .RESET_EXT_CYCLES(RESET_EXT_CYCLES)
) uhcmi_top_properties_inst (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ext_reset_in_i(ext_reset_in_i),
  .cs_n_i(cs_n_i), .port_select_i(port_select_i),
  .host_data_bus_o(host_data_bus_o),
  .host_data_bus_oe_n_o(host_data_bus_oe_n_o), .int_n_o(int_n_o),
  .txd_oe_n_o(txd_oe_n_o), .act_n_o(act_n_o), .rst_o(rst_o),
  .rst_n_o(rst_n_o), .serial_mode_o(serial_mode_o),
  .device_mode_en_o(device_mode_en_o), .cmd_valid_o(cmd_valid_o),
  .data_rd_ack_o(data_rd_ack_o), .bus_change_i(bus_change_i),
  .cmd_done_i(cmd_done_i), .dev_attached_i(dev_attached_i)
);

// file: bench/uhcmi_host_model.sv
`timescale 1ns/1ns
module uhcmi_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] bus_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            port_select_o,
  output logic [7:0]      data_o
);
  logic single;

  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    port_select_o = 1'b0;
    data_o = 8'h00;
    single = 1'b0;
  end

  // single-strobe hosts keep the read strobe low for good
  task automatic set_single(input logic on);
    @(posedge mclk_i);
    single = on;
    rd_n_o <= !on;
  endtask : set_single

  // strobe held six clocks, well past the four the port needs
  task automatic access(input logic wr, input logic ps, input logic [7:0] d,
                        input logic sel_n, output logic [7:0] q);
    @(posedge mclk_i);
    cs_n_o <= sel_n;
    port_select_o <= ps;
    data_o <= wr ? d : ~data_o;
    if (single)
      wr_n_o <= !wr;
    else if (wr)
      wr_n_o <= 1'b0;
    else
      rd_n_o <= 1'b0;
    repeat (6) @(posedge mclk_i);
    q = bus_i;
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    rd_n_o <= !single;
    repeat (3) @(posedge mclk_i);
    // released lines show the opposite level, not the last value
    data_o <= ~data_o;
    port_select_o <= ~ps;
    repeat (2) @(posedge mclk_i);
  endtask : access
endmodule : uhcmi_host_model

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int EXT = 20;
  localparam int BAUD_DIV = 20000000 / 9600;
  logic        mclk_i, arst_n_i, ext_reset_in_i, rxd_i, txd_i, strap;
  logic        cs_n, rd_n, wr_n, ps, bus_change_i, cmd_done_i, oe_n;
  logic        dev_attached_i, link_div_load_i, sie_in_wr_i, int_n_o;
  logic        ser_tx_valid_i, ser_tx_ready_o;
  logic        txd_o, txd_oe_n_o, act_n_o, rst_o, rst_n_o, serial_mode_o;
  logic        device_mode_en_o, cmd_valid_o, data_valid_o, data_rd_ack_o;
  logic [6:0]  token_status_i, out_len_o;
  logic [5:0]  sie_out_addr_i, sie_in_addr_i;
  logic [15:0] link_div_i;
  logic [7:0]  bus, host_d, dev_d, sie_in_data_i, sie_out_data_o;
  logic [7:0]  cmd_code_o, data_o, last_cmd, last_dat, q;
  int          n_mismatch = 0, compares = 0, n_cmd = 0, n_dat = 0, n_ack = 0;

  assign bus = oe_n ? host_d : dev_d;
  assign txd_i = txd_oe_n_o ? strap : txd_o;

  uhcmi_top #(.RESET_EXT_CYCLES(EXT), .BUF_BYTES(64)) uhcmi_top_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ext_reset_in_i(ext_reset_in_i),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .port_select_i(ps),
    .host_data_bus_i(bus), .host_data_bus_o(dev_d),
    .host_data_bus_oe_n_o(oe_n), .int_n_o(int_n_o), .rxd_i(rxd_i),
    .txd_i(txd_i), .txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o),
    .act_n_o(act_n_o), .rst_o(rst_o), .rst_n_o(rst_n_o),
    .serial_mode_o(serial_mode_o), .device_mode_en_o(device_mode_en_o),
    .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o),
    .data_valid_o(data_valid_o), .data_o(data_o),
    .data_rd_ack_o(data_rd_ack_o), .token_status_i(token_status_i),
    .bus_change_i(bus_change_i), .cmd_done_i(cmd_done_i),
    .dev_attached_i(dev_attached_i), .link_div_load_i(link_div_load_i),
    .link_div_i(link_div_i), .ser_tx_valid_i(ser_tx_valid_i),
    .ser_tx_data_i(8'ha5), .ser_tx_ready_o(ser_tx_ready_o),
    .sie_out_addr_i(sie_out_addr_i),
    .sie_out_data_o(sie_out_data_o), .sie_in_wr_i(sie_in_wr_i),
    .sie_in_addr_i(sie_in_addr_i), .sie_in_data_i(sie_in_data_i),
    .out_len_o(out_len_o)
  );

  uhcmi_host_model uhcmi_host_model_inst (
    .mclk_i(mclk_i), .bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .port_select_o(ps), .data_o(host_d)
  );

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // pulses last one cycle, so they are tallied as they pass
  always @(posedge mclk_i) begin
    if (cmd_valid_o === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_code_o;
    end
    if (data_valid_o === 1'b1) begin
      n_dat++;
      last_dat = data_o;
    end
    if (data_rd_ack_o === 1'b1)
      n_ack++;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic wr, input logic p, input logic [7:0] d,
                     input logic sel_n = 1'b0);
    uhcmi_host_model_inst.access(wr, p, d, sel_n, q);
  endtask : acc

  task automatic wait_run(output int n);
    n = 0;
    while (rst_o !== 1'b0 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
  endtask : wait_run

  task automatic do_reset(input logic s);
    int n;
    @(posedge mclk_i);
    strap <= s;
    arst_n_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    check(rst_o, 1'b1);
    check(rst_n_o, 1'b0);
    arst_n_i <= 1'b1;
    wait_run(n);
    check(n >= EXT && n < 200, 1'b1);
    check(serial_mode_o, s);
    check(device_mode_en_o, !s);
  endtask : do_reset

  task automatic t_ext();
    int n;
    @(posedge mclk_i);
    ext_reset_in_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    check(rst_o, 1'b1);
    ext_reset_in_i <= 1'b0;
    wait_run(n);
    check(n >= EXT && n <= EXT + 6, 1'b1);
  endtask : t_ext

  // command first, then its data bytes
  task automatic t_write();
    acc(1'b1, 1'b1, 8'h15);
    check(last_cmd, 8'h15);
    check(n_cmd, 1);
    for (logic [7:0] b = 8'ha0; b < 8'ha3; b++) begin
      acc(1'b1, 1'b0, b);
      check(last_dat, b);
    end
    check(out_len_o, 7'h03);
    sie_out_addr_i <= 6'h01;
    repeat (2) @(posedge mclk_i);
    check(sie_out_data_o, 8'ha1);
  endtask : t_write

  task automatic t_read();
    logic [7:0] pat [2];
    pat = '{8'h3c, 8'hc3};
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i);
      sie_in_wr_i <= 1'b1;
      sie_in_addr_i <= 6'(i);
      sie_in_data_i <= pat[i];
    end
    @(posedge mclk_i);
    sie_in_wr_i <= 1'b0;
    acc(1'b1, 1'b1, 8'h27);
    for (int i = 0; i < 2; i++) begin
      acc(1'b0, 1'b0, 8'h00);
      check(q, pat[i]);
    end
    check(n_ack, 2);
    acc(1'b1, 1'b1, 8'h5f, 1'b1);
    acc(1'b0, 1'b0, 8'h00, 1'b1);
    check(n_cmd, 2);
    check(n_ack, 2);
  endtask : t_read

  task automatic t_irq();
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      bus_change_i <= (k == 0);
      cmd_done_i <= (k == 1);
      @(posedge mclk_i);
      bus_change_i <= 1'b0;
      cmd_done_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check(int_n_o, 1'b0);
      acc(1'b0, 1'b1, 8'h00);
      check(q, 8'h2a);
      check(int_n_o, 1'b1);
      acc(1'b0, 1'b1, 8'h00);
      check(q, 8'haa);
    end
  endtask : t_irq

  task automatic t_single();
    uhcmi_host_model_inst.set_single(1'b1);
    acc(1'b1, 1'b1, 8'h06);
    check(last_cmd, 8'h06);
    acc(1'b0, 1'b0, 8'h00);
    check(q, 8'h3c);
    check(n_ack, 3);
    uhcmi_host_model_inst.set_single(1'b0);
    dev_attached_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    check(act_n_o, 1'b0);
    dev_attached_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    check(act_n_o, 1'b1);
  endtask : t_single

  task automatic frame(input logic [8:0] w, input int div);
    logic [10:0] f;
    f = {1'b1, w, 1'b0};
    @(posedge mclk_i);
    for (int i = 0; i < 11; i++) begin
      rxd_i <= f[i];
      repeat (div) @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
  endtask : frame

  task automatic t_serial();
    logic [10:0] f;
    do_reset(1'b1);
    acc(1'b1, 1'b1, 8'h11);
    check(n_cmd, 3);
    frame(9'h05a, BAUD_DIV);
    check(last_dat, 8'h5a);
    link_div_i <= 16'h0010;
    link_div_load_i <= 1'b1;
    @(posedge mclk_i);
    link_div_load_i <= 1'b0;
    frame(9'h13c, 16);
    check(last_cmd, 8'h3c);
    check(n_cmd, 4);
    // transmit one byte at the 16-cycle rate, sampled mid-bit
    @(posedge mclk_i);
    ser_tx_valid_i <= 1'b1;
    @(posedge mclk_i);
    ser_tx_valid_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    check(ser_tx_ready_o, 1'b0);
    for (int i = 0; i < 11; i++) begin
      f[i] = txd_o;
      repeat (16) @(posedge mclk_i);
    end
    check(f, {2'b10, 8'ha5, 1'b0});
    check(ser_tx_ready_o, 1'b1);
  endtask : t_serial

  initial begin
    arst_n_i = 1'b0;
    ext_reset_in_i = 1'b0;
    rxd_i = 1'b1;
    strap = 1'b0;
    bus_change_i = 1'b0;
    cmd_done_i = 1'b0;
    dev_attached_i = 1'b0;
    link_div_load_i = 1'b0;
    ser_tx_valid_i = 1'b0;
    link_div_i = 16'h0010;
    sie_in_wr_i = 1'b0;
    sie_in_addr_i = 6'h00;
    sie_in_data_i = 8'h00;
    sie_out_addr_i = 6'h00;
    token_status_i = 7'h2a;
    do_reset(1'b0);
    t_ext();
    t_write();
    t_read();
    t_irq();
    t_single();
    t_serial();
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge mclk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule : testbench
